// [core/io_port_ctrl.sv]
`timescale 1ns/1ps
`default_nettype none
module io_port_ctrl
  import io_ctrl_pkg::*;
#(
  parameter int W = 8,
  parameter int TX_PIN = 1
) (
  // Clock and reset
  input  wire logic         core_clk,
  input  wire logic         rst,
  // CPU register access
  cpu_io_if.dev             bus,
  // Port A pins
  input  wire logic [W-1:0] pa_in,
  output var  logic [W-1:0] pa_out,
  output var  logic [W-1:0] pa_oe,
  output var  logic [W-1:0] pa_pullup,
  // Port B latch
  output var  logic [W-1:0] port_b_output_latch,
  // Fuses, locks, core status
  input  wire logic         debug_port_fuse,
  input  wire logic         app_boot_lock,
  input  wire logic         boot_side_lock,
  input  wire logic         exec_in_boot,
  input  wire logic         sleep_exec,
  input  wire logic         tx_enable,
  // Control outputs
  output var  logic         debug_port_enable,
  output var  logic         vector_select,
  output var  logic         irq_block,
  output var  logic         brownout_detector_off
);
  logic [W-1:0] port_a_direction;
  logic [W-1:0] port_a_output_latch;
  logic [W-1:0] sync1;
  logic [W-1:0] sync2;
  logic [W-1:0] sync3;
  logic [W-1:0] pin_level;
  logic [7:0]   mcu_control;
  logic [2:0]   jtd_cnt;
  logic         jtd_val;
  logic [2:0]   bse_cnt;
  logic [2:0]   brownout_sleep_off_cnt;
  logic [2:0]   vce_cnt;
  logic         post_vsel;
  logic [7:0]   rdata;

  // Address decode; I/O space is remapped up by the offset
  wire       io_ok   = bus.addr <= IO_SPACE_TOP;
  wire [7:0] eff     = bus.io_space ? 8'(bus.addr + IO_SPACE_OFS) : bus.addr;
  wire       sel_ok  = !bus.io_space || io_ok;
  wire       wr      = bus.wr && sel_ok;
  wire       rd      = bus.rd && sel_ok;
  wire       wr_pin  = wr && eff == OFS_PIN_A;
  wire       wr_dir  = wr && eff == OFS_DIR_A;
  wire       wr_out  = wr && eff == OFS_OUT_A;
  wire       wr_outb = wr && eff == OFS_OUT_B;
  wire       wr_ctl  = wr && eff == OFS_MCU_CTRL;
  wire [7:0] wd      = bus.wdata;

  // Timed-sequence decode
  wire jtd_arm  = wr_ctl && wd[BIT_DBG_DIS] != mcu_control[BIT_DBG_DIS];
  wire jtd_hit  = jtd_arm && jtd_cnt != 3'd0 && jtd_val == wd[BIT_DBG_DIS];
  wire bse_arm  = wr_ctl && wd[BIT_BOD_OFF] && wd[BIT_BOD_UNLOCK];
  wire brownout_sleep_off_set = wr_ctl && bse_cnt != 3'd0 && wd[BIT_BOD_OFF]
                  && !wd[BIT_BOD_UNLOCK];
  wire vce_on   = vce_cnt != 3'd0;
  wire vce_arm  = wr_ctl && wd[BIT_VCE];
  wire vsel_wr  = wr_ctl && vce_on && !wd[BIT_VCE];
  wire brownout_sleep_off_on  = brownout_sleep_off_cnt != 3'd0 && brownout_sleep_off_cnt <= BOD_HOLD;

  // Pin level from second and third stage once they agree
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sync1     <= '0;
      sync2     <= '0;
      sync3     <= '0;
      pin_level <= '0;
    end else begin
      sync1 <= pa_in;
      sync2 <= sync1;
      sync3 <= sync2;
      for (int i = 0; i < W; i++) begin
        if (sync2[i] == sync3[i]) pin_level[i] <= sync3[i];
      end
    end
  end

  // Port registers; pin-register ones invert the latch
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      port_a_direction    <= '0;
      port_a_output_latch <= '0;
      port_b_output_latch <= '0;
    end else begin
      if (wr_dir) port_a_direction <= wd[W-1:0];
      if (wr_out) port_a_output_latch <= wd[W-1:0];
      else if (wr_pin) port_a_output_latch <= port_a_output_latch ^ wd[W-1:0];
      if (wr_outb) port_b_output_latch <= wd[W-1:0];
    end
  end

  // Debug disable needs two equal writes inside the window
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      jtd_cnt <= '0;
      jtd_val <= 1'b0;
    end else if (jtd_arm && !jtd_hit) begin
      jtd_cnt <= UNLOCK_CYCLES;
      jtd_val <= wd[BIT_DBG_DIS];
    end else if (jtd_hit) begin
      jtd_cnt <= '0;
    end else if (jtd_cnt != 3'd0) begin
      jtd_cnt <= jtd_cnt - 3'd1;
    end
  end

  // Brown-out unlock window, then delay plus hold on the sleep-off bit
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      bse_cnt  <= '0;
      brownout_sleep_off_cnt <= '0;
    end else begin
      if (bse_arm) bse_cnt <= UNLOCK_CYCLES;
      else if (brownout_sleep_off_set) bse_cnt <= '0;
      else if (bse_cnt != 3'd0) bse_cnt <= bse_cnt - 3'd1;
      if (brownout_sleep_off_set) brownout_sleep_off_cnt <= 3'(BOD_DELAY + BOD_HOLD);
      else if (brownout_sleep_off_cnt != 3'd0) brownout_sleep_off_cnt <= brownout_sleep_off_cnt - 3'd1;
    end
  end

  // Vector change window; one extra cycle covers the following instruction
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      vce_cnt   <= '0;
      post_vsel <= 1'b0;
    end else begin
      if (vce_arm) vce_cnt <= UNLOCK_CYCLES;
      else if (vsel_wr) vce_cnt <= '0;
      else if (vce_on) vce_cnt <= vce_cnt - 3'd1;
      post_vsel <= vsel_wr;
    end
  end

  // Control register image; bits 3 and 2 never store
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      mcu_control <= RESET_BYTE;
    end else begin
      if (jtd_hit) mcu_control[BIT_DBG_DIS] <= wd[BIT_DBG_DIS];
      mcu_control[BIT_BOD_OFF]    <= brownout_sleep_off_set || (brownout_sleep_off_cnt > 3'd1);
      mcu_control[BIT_BOD_UNLOCK] <= bse_arm || (bse_cnt > 3'd1 && !brownout_sleep_off_set);
      if (wr_ctl) mcu_control[BIT_PUD] <= wd[BIT_PUD];
      if (vsel_wr) mcu_control[BIT_VSEL] <= wd[BIT_VSEL];
      mcu_control[BIT_VCE] <= vce_arm || (vce_cnt > 3'd1 && !vsel_wr);
    end
  end

  // Read mux
  always_comb begin
    rdata = '0;
    case (eff)
      OFS_PIN_A:    rdata[W-1:0] = pin_level;
      OFS_DIR_A:    rdata[W-1:0] = port_a_direction;
      OFS_OUT_A:    rdata[W-1:0] = port_a_output_latch;
      OFS_OUT_B:    rdata[W-1:0] = port_b_output_latch;
      OFS_MCU_CTRL: rdata = mcu_control & CTRL_RW_MASK;
      default:      rdata = '0;
    endcase
  end

  // Registered outputs
  wire blk_sec = (mcu_control[BIT_VSEL] && app_boot_lock && !exec_in_boot)
               || (!mcu_control[BIT_VSEL] && boot_side_lock && exec_in_boot);
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      bus.rdata             <= '0;
      pa_out                <= '0;
      pa_oe                 <= '0;
      pa_pullup             <= '0;
      debug_port_enable     <= 1'b0;
      vector_select         <= 1'b0;
      irq_block             <= 1'b0;
      brownout_detector_off <= 1'b0;
    end else begin
      bus.rdata <= rd ? rdata : 8'h00;
      pa_out    <= port_a_output_latch;
      for (int i = 0; i < W; i++) begin
        pa_oe[i]     <= port_a_direction[i] || (i == TX_PIN && tx_enable);
        pa_pullup[i] <= !port_a_direction[i] && port_a_output_latch[i]
                        && !mcu_control[BIT_PUD];
      end
      debug_port_enable <= debug_port_fuse && !mcu_control[BIT_DBG_DIS];
      vector_select     <= mcu_control[BIT_VSEL];
      // Separate line so the core's global enable flag is never touched
      irq_block <= vce_arm || vce_on || vsel_wr || post_vsel || blk_sec;
      // Loaded on every sleep cycle; set only when sleep hits the active span
      if (sleep_exec) brownout_detector_off <= brownout_sleep_off_on;
    end
  end
endmodule : io_port_ctrl
`default_nettype wire

// [core/io_ctrl_pkg.sv]
package io_ctrl_pkg;
  // Data-space offsets
  localparam logic [7:0] OFS_PIN_A      = 8'h20;
  localparam logic [7:0] OFS_DIR_A      = 8'h21;
  localparam logic [7:0] OFS_OUT_A      = 8'h22;
  localparam logic [7:0] OFS_OUT_B      = 8'h25;
  localparam logic [7:0] OFS_MCU_CTRL   = 8'h55;
  // Short I/O window
  localparam logic [7:0] IO_SPACE_OFS   = 8'h20;
  localparam logic [7:0] IO_SPACE_TOP   = 8'h3f;
  localparam logic [7:0] EXT_IO_BASE    = 8'h60;
  // Control register fields
  localparam int BIT_DBG_DIS    = 7;
  localparam int BIT_BOD_OFF    = 6;
  localparam int BIT_BOD_UNLOCK = 5;
  localparam int BIT_PUD        = 4;
  localparam int BIT_VSEL       = 1;
  localparam int BIT_VCE        = 0;
  localparam logic [7:0] CTRL_RW_MASK = 8'hf3;
  localparam logic [7:0] RESET_BYTE   = 8'h00;
  // Timed windows in CPU clock cycles
  localparam logic [2:0] UNLOCK_CYCLES  = 3'd4;
  localparam logic [2:0] BOD_DELAY      = 3'd3;
  localparam logic [2:0] BOD_HOLD       = 3'd3;
  // Host command port register indices and command codes
  localparam logic [3:0] H_ADDR    = 4'h0;
  localparam logic [3:0] H_WDATA   = 4'h1;
  localparam logic [3:0] H_CMD     = 4'h2;
  localparam logic [3:0] H_RDATA   = 4'h3;
  localparam logic [3:0] H_STATUS  = 4'h4;
  localparam logic [7:0] CMD_ST_DATA = 8'h01;
  localparam logic [7:0] CMD_LD_DATA = 8'h02;
  localparam logic [7:0] CMD_OUT_IO  = 8'h03;
  localparam logic [7:0] CMD_IN_IO   = 8'h04;
endpackage : io_ctrl_pkg

// [core/cpu_io_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface cpu_io_if;
  logic       io_space;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic       wr;
  logic       rd;
  logic [7:0] rdata;
  modport dev (input io_space, addr, wdata, wr, rd, output rdata);
  modport cpu (output io_space, addr, wdata, wr, rd, input rdata);
endinterface : cpu_io_if
`default_nettype wire

// [core/cpu_io_master.sv]
`timescale 1ns/1ps
`default_nettype none
// CPU-side end: software fills address and data, then issues a command
module cpu_io_master
  import io_ctrl_pkg::*;
(
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst,
  // Software port
  input  wire logic [3:0] sw_addr,
  input  wire logic [7:0] sw_wdata,
  input  wire logic       sw_wr,
  input  wire logic       sw_rd,
  output var  logic [7:0] sw_rdata,
  // Device side
  cpu_io_if.cpu           bus
);
  logic [7:0] addr_q;
  logic [7:0] wdata_q;
  logic [7:0] rd_q;
  logic       pend;
  logic       busy;
  logic       got;
  logic [7:0] sel;

  // Command issue; every command reaches the bus, so only the device refuses addresses
  wire cmd    = sw_wr && sw_addr == H_CMD;
  wire io_cmd = sw_wdata == CMD_OUT_IO || sw_wdata == CMD_IN_IO;
  wire do_wr  = cmd && (sw_wdata == CMD_ST_DATA || sw_wdata == CMD_OUT_IO);
  wire do_rd  = cmd && (sw_wdata == CMD_LD_DATA || sw_wdata == CMD_IN_IO);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      addr_q       <= '0;
      wdata_q      <= '0;
      rd_q         <= '0;
      pend         <= 1'b0;
      busy         <= 1'b0;
      got          <= 1'b0;
      bus.io_space <= 1'b0;
      bus.addr     <= '0;
      bus.wdata    <= '0;
      bus.wr       <= 1'b0;
      bus.rd       <= 1'b0;
    end else begin
      if (sw_wr && sw_addr == H_ADDR) addr_q <= sw_wdata;
      if (sw_wr && sw_addr == H_WDATA) wdata_q <= sw_wdata;
      bus.wr       <= do_wr;
      bus.rd       <= do_rd;
      bus.io_space <= cmd && io_cmd;
      bus.addr     <= addr_q;
      bus.wdata    <= wdata_q;
      pend         <= bus.rd;
      busy         <= do_rd || bus.rd;
      if (pend) rd_q <= bus.rdata;
      if (pend) got <= 1'b1;
      else if (do_rd) got <= 1'b0;
    end
  end

  // Software read-back
  always_comb begin
    case (sw_addr)
      H_ADDR:   sel = addr_q;
      H_WDATA:  sel = wdata_q;
      H_RDATA:  sel = rd_q;
      H_STATUS: sel = {6'h00, busy, got};
      default:  sel = 8'h00;
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) sw_rdata <= '0;
    else     sw_rdata <= sw_rd ? sel : 8'h00;
  end
endmodule : cpu_io_master
`default_nettype wire

// [verification/io_port_ctrl_checker.sv]
`timescale 1ns/1ps
`default_nettype none
module io_port_ctrl_checker
  import io_ctrl_pkg::*;
(
  // Clock, reset and bus
  input wire logic       core_clk,
  input wire logic       rst,
  input wire logic       io_space,
  input wire logic [7:0] addr,
  input wire logic       wr,
  input wire logic       rd,
  input wire logic [7:0] rdata,
  // Pins and control outputs
  input wire logic [7:0] pa_out,
  input wire logic [7:0] pa_pullup,
  input wire logic       debug_port_fuse,
  input wire logic       debug_port_enable,
  input wire logic       vector_select,
  input wire logic       irq_block,
  input wire logic       sleep_exec,
  input wire logic       brownout_detector_off
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // Read data only in its slot, so stale bytes never leak
  property p_rdata_idle; !rd |=> rdata == 8'h00; endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside slot");
  property p_strobes; !(wr && rd); endproperty
  a_strobes: assert property (p_strobes) else $error("both strobes high");
  property p_ext; io_space && rd && addr > IO_SPACE_TOP |=> rdata == 8'h00; endproperty
  a_ext: assert property (p_ext) else $error("short access beyond window");
  property p_resv; rd && !io_space && addr == OFS_MCU_CTRL |=> rdata[3:2] == 2'b00; endproperty
  a_resv: assert property (p_resv) else $error("reserved control bits set");
  // A pull-up needs a high latch bit behind it
  property p_pullup; (pa_pullup & ~pa_out) == 8'h00; endproperty
  a_pullup: assert property (p_pullup) else $error("pull-up on low latch");
  property p_dbg; debug_port_enable |-> $past(debug_port_fuse); endproperty
  a_dbg: assert property (p_dbg) else $error("debug port without fuse");
  property p_blk; $rose(irq_block) |-> ##[1:7] !irq_block; endproperty
  a_blk: assert property (p_blk) else $error("interrupt block too long");
  property p_bod; $changed(brownout_detector_off) |-> $past(sleep_exec); endproperty
  a_bod: assert property (p_bod) else $error("detector moved without sleep");
  // Vector select may only follow a bus write by a few cycles
  property p_vsel;
    $changed(vector_select) |-> $past(wr) || $past(wr, 2) || $past(wr, 3);
  endproperty
  a_vsel: assert property (p_vsel) else $error("vector select moved alone");
  c_ext: cover property (io_space && rd && addr > IO_SPACE_TOP);
  c_blk: cover property ($rose(irq_block));
  c_bod: cover property ($rose(brownout_detector_off));
  c_vsel: cover property ($rose(vector_select));
endmodule : io_port_ctrl_checker
`default_nettype wire

// [verification/io_port_and_mcu_control_regs_tb.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin miscompares++; $display("wrong value at %0t: got %h want %h", $time, a, b); end end
module io_port_and_mcu_control_regs_tb
  import io_ctrl_pkg::*;
;
  logic       core_clk, rst, sw_wr, sw_rd, fuse, tx, sleep, dpe, vsel, blk, brownout_detector;
  logic [3:0] sw_addr;
  logic [7:0] sw_wdata, sw_rdata, pa_in, pa_out, pa_oe, pa_pullup, pb, v;
  logic       lock_app, lock_boot, in_boot;
  logic       saw_blk = 1'b0;
  logic       saw_bod = 1'b0;
  int         miscompares, samples_checked, cycles;
  localparam logic [7:0] REGS [4] = '{OFS_DIR_A, OFS_OUT_A, OFS_OUT_B, OFS_MCU_CTRL};
  localparam logic [7:0] CTRL_IO = OFS_MCU_CTRL - IO_SPACE_OFS;
  cpu_io_if bus_if();
  cpu_io_master cpu_io_master_inst(.core_clk, .rst, .sw_addr, .sw_wdata, .sw_wr, .sw_rd,
    .sw_rdata, .bus(bus_if));
  // Locks and code section are bench-driven so section blocking gets exercised
  io_port_ctrl io_port_ctrl_inst(.core_clk, .rst, .bus(bus_if), .pa_in, .pa_out, .pa_oe,
    .pa_pullup, .port_b_output_latch(pb), .debug_port_fuse(fuse), .app_boot_lock(lock_app),
    .boot_side_lock(lock_boot), .exec_in_boot(in_boot), .sleep_exec(sleep), .tx_enable(tx),
    .debug_port_enable(dpe), .vector_select(vsel), .irq_block(blk), .brownout_detector_off(brownout_detector));
  io_port_ctrl_checker io_port_ctrl_checker_inst(.core_clk, .rst, .io_space(bus_if.io_space),
    .addr(bus_if.addr), .wr(bus_if.wr), .rd(bus_if.rd), .rdata(bus_if.rdata), .pa_out,
    .pa_pullup, .debug_port_fuse(fuse), .debug_port_enable(dpe), .vector_select(vsel),
    .irq_block(blk), .sleep_exec(sleep), .brownout_detector_off(brownout_detector));
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  // Sticky flags catch short pulses between checks; cycle ceiling cuts a hang
  always @(posedge core_clk) begin
    if (blk === 1'b1) saw_blk <= 1'b1;
    if (brownout_detector === 1'b1) saw_bod <= 1'b1;
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      miscompares++;
      summarize();
    end
  end
  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : summarize
  // One software-port cycle; holds strobes so back-to-back writes need no gap
  task automatic op(input logic w, input logic r, input logic [3:0] a, input logic [7:0] d);
    sw_wr <= w;
    sw_rd <= r;
    sw_addr <= a;
    sw_wdata <= d;
    @(posedge core_clk);
  endtask : op
  task automatic sw_get(input logic [3:0] a, output logic [7:0] q);
    op(1'b0, 1'b1, a, 8'h00);
    sw_rd <= 1'b0;
    #1 q = sw_rdata;
    @(posedge core_clk);
  endtask : sw_get
  task automatic dev_wr(input logic io, input logic [7:0] a, input logic [7:0] d);
    op(1'b1, 1'b0, H_ADDR, a);
    op(1'b1, 1'b0, H_WDATA, d);
    op(1'b1, 1'b0, H_CMD, io ? CMD_OUT_IO : CMD_ST_DATA);
    op(1'b0, 1'b0, H_ADDR, 8'h00);
  endtask : dev_wr
  // Polls the done flag with a bound instead of trusting a fixed delay
  task automatic dev_rd(input logic io, input logic [7:0] a, output logic [7:0] q);
    op(1'b1, 1'b0, H_ADDR, a);
    op(1'b1, 1'b0, H_CMD, io ? CMD_IN_IO : CMD_LD_DATA);
    op(1'b0, 1'b0, H_ADDR, 8'h00);
    for (int i = 0; i < 8; i++) begin
      sw_get(H_STATUS, q);
      if (q[0] === 1'b1) break;
    end
    sw_get(H_RDATA, q);
  endtask : dev_rd
  initial begin
    {sw_wr, sw_rd, sw_addr, sw_wdata, tx, sleep, lock_app, lock_boot, in_boot} = '0;
    rst = 1'b1;
    fuse = 1'b1;
    pa_in = 8'h3c;
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    foreach (REGS[i]) begin
      dev_rd(1'b0, REGS[i], v);
      `CHK(v, 8'h00)
    end
    dev_wr(1'b1, OFS_OUT_B - IO_SPACE_OFS, 8'ha5);
    dev_rd(1'b0, OFS_OUT_B, v);
    `CHK(v, 8'ha5)
    `CHK(pb, 8'ha5)
    // Short access above the window reaches the bus; the device must answer zero
    dev_rd(1'b1, 8'h40, v);
    `CHK(v, 8'h00)
    // Latch, direction, then a toggle through the pin register
    dev_wr(1'b0, OFS_OUT_A, 8'h0f);
    dev_wr(1'b1, OFS_DIR_A - IO_SPACE_OFS, 8'h01);
    dev_wr(1'b0, OFS_PIN_A, 8'h05);
    dev_rd(1'b0, OFS_OUT_A, v);
    `CHK(v, 8'h0a)
    `CHK(pa_out, 8'h0a)
    `CHK(pa_pullup, 8'h0a)
    tx <= 1'b1;
    dev_rd(1'b0, OFS_PIN_A, v);
    `CHK(v, 8'h3c)
    `CHK(pa_oe, 8'h03)
    dev_wr(1'b0, OFS_MCU_CTRL, 8'h1c);
    dev_rd(1'b1, CTRL_IO, v);
    `CHK(v, 8'h10)
    `CHK(pa_pullup, 8'h00)
    // Debug port needs the fuse as well as a clear disable bit
    `CHK(dpe, 1'b1)
    fuse <= 1'b0;
    repeat (2) op(1'b0, 1'b0, H_ADDR, 8'h00);
    `CHK(dpe, 1'b0)
    fuse <= 1'b1;
    // Debug disable: a lone write must not stick, a pair must; no debugger is attached here
    dev_wr(1'b0, OFS_MCU_CTRL, 8'h90);
    dev_rd(1'b0, OFS_MCU_CTRL, v);
    `CHK(v, 8'h10)
    dev_wr(1'b0, OFS_MCU_CTRL, 8'h90);
    dev_wr(1'b0, OFS_MCU_CTRL, 8'h90);
    dev_rd(1'b0, OFS_MCU_CTRL, v);
    `CHK(v, 8'h90)
    `CHK(dpe, 1'b0)
    dev_wr(1'b0, OFS_MCU_CTRL, 8'h91);
    dev_wr(1'b0, OFS_MCU_CTRL, 8'h92);
    // The select output is registered behind the control bit, so let it settle
    repeat (2) op(1'b0, 1'b0, H_ADDR, 8'h00);
    `CHK(vsel, 1'b1)
    `CHK(saw_blk, 1'b1)
    dev_wr(1'b0, OFS_MCU_CTRL, 8'h91);
    repeat (8) op(1'b0, 1'b0, H_ADDR, 8'h00);
    dev_rd(1'b0, OFS_MCU_CTRL, v);
    `CHK(v, 8'h92)
    `CHK(blk, 1'b0)
    // Vectors in boot section: locked application code is blocked, boot code is not
    lock_app <= 1'b1;
    repeat (2) op(1'b0, 1'b0, H_ADDR, 8'h00);
    `CHK(blk, 1'b1)
    in_boot <= 1'b1;
    lock_boot <= 1'b1;
    repeat (2) op(1'b0, 1'b0, H_ADDR, 8'h00);
    `CHK(blk, 1'b0)
    lock_app <= 1'b0;
    lock_boot <= 1'b0;
    in_boot <= 1'b0;
    // Sleep without the unlock pair leaves the detector on
    sleep <= 1'b1;
    op(1'b0, 1'b0, H_ADDR, 8'h00);
    sleep <= 1'b0;
    op(1'b0, 1'b0, H_ADDR, 8'h00);
    `CHK(saw_bod, 1'b0)
    dev_wr(1'b0, OFS_MCU_CTRL, 8'hf2);
    dev_wr(1'b0, OFS_MCU_CTRL, 8'hd2);
    sleep <= 1'b1;
    repeat (8) op(1'b0, 1'b0, H_ADDR, 8'h00);
    sleep <= 1'b0;
    `CHK(saw_bod, 1'b1)
    dev_rd(1'b0, OFS_MCU_CTRL, v);
    `CHK(v, 8'h92)
    // Mid-run reset: direction and select drop back, transmitter still forces its pin
    rst <= 1'b1;
    repeat (2) op(1'b0, 1'b0, H_ADDR, 8'h00);
    rst <= 1'b0;
    op(1'b0, 1'b0, H_ADDR, 8'h00);
    `CHK(vsel, 1'b0)
    dev_rd(1'b0, OFS_DIR_A, v);
    `CHK(v, 8'h00)
    `CHK(pa_oe, 8'h02)
    `CHK(pa_out, 8'h00)
    summarize();
  end
endmodule : io_port_and_mcu_control_regs_tb
`default_nettype wire
